// ### hw/bct_pkg.sv
// Constants, register map and types of the BCD calendar timekeeper
// Summary of operation
// - Count 32-kHz clock into one-second ticks
// - Seconds, minutes, hours held as packed BCD
// - Day, month, year, weekday in BCD
// - Periodic tick every second, minute, hour, day
// - Alarm when time and date match
// - Each event gated by own enable
// - Sleep masks ticks, unmasked on wakeup
// - Years 00-99, divisible by four leap
// - Months 01-12 with correct last day
// - Weekday cycles 0 to 6 daily
// - Hours 00-23 or 1-12 with PM
// - Minutes and seconds wrap after 59
// - Time writes accepted while running
// - Clearing run request freezes, running status shows halt
// - Round sets nearest minute at next second
// - Round bit clears itself when applied
// - Compensation added hourly at hour plus second
// - Compensated second lasts 32768 minus value
// - New compensation used at next event
// - Five 8-bit scratch registers retained
// - Only power-on reset clears timekeeping
package bct_pkg;

  // Register indices
  localparam logic [7:0] REG_SECONDS   = 8'h00;
  localparam logic [7:0] REG_MINUTES   = 8'h01;
  localparam logic [7:0] REG_HOURS     = 8'h02;
  localparam logic [7:0] REG_DAYS      = 8'h03;
  localparam logic [7:0] REG_MONTHS    = 8'h04;
  localparam logic [7:0] REG_YEARS     = 8'h05;
  localparam logic [7:0] REG_WEEKDAYS  = 8'h06;
  localparam logic [7:0] REG_AL_SEC    = 8'h08;
  localparam logic [7:0] REG_AL_MIN    = 8'h09;
  localparam logic [7:0] REG_AL_HOUR   = 8'h0a;
  localparam logic [7:0] REG_AL_DAY    = 8'h0b;
  localparam logic [7:0] REG_AL_MONTH  = 8'h0c;
  localparam logic [7:0] REG_AL_YEAR   = 8'h0d;
  localparam logic [7:0] REG_CTRL      = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h11;
  localparam logic [7:0] REG_EVT_CTRL  = 8'h12;
  localparam logic [7:0] REG_COMP_LSB  = 8'h13;
  localparam logic [7:0] REG_COMP_MSB  = 8'h14;
  localparam logic [7:0] REG_SCRATCH0  = 8'h15;
  localparam int         SCRATCH_NUM   = 5;

  // Control register fields
  localparam int CTRL_RUN       = 0;
  localparam int CTRL_ROUND     = 1;
  localparam int CTRL_AUTO_COMP = 2;
  localparam int CTRL_MODE_12H  = 5;
  // Event control fields
  localparam int EVT_PERIOD_LO  = 0;
  localparam int EVT_TICK_EN    = 2;
  localparam int EVT_ALARM_EN   = 3;
  localparam int EVT_SLEEP_MASK = 4;
  // Status and hours register fields
  localparam int STAT_RUNNING   = 1;
  localparam int HOUR_PM_BIT    = 7;

  // BCD limits and reset values
  localparam logic [7:0] BCD_ZERO     = 8'h00;
  localparam logic [7:0] BCD_ONE      = 8'h01;
  localparam logic [3:0] BCD_NINE     = 4'h9;
  localparam logic [7:0] SEC_MAX      = 8'h59;
  localparam logic [7:0] SEC_HALF     = 8'h30;
  localparam logic [7:0] HOUR24_MAX   = 8'h23;
  localparam logic [7:0] HOUR12_MAX   = 8'h12;
  localparam logic [7:0] HOUR12_LAST  = 8'h11;
  localparam logic [7:0] MONTH_MAX    = 8'h12;
  localparam logic [7:0] YEAR_MAX     = 8'h99;
  localparam logic [7:0] WDAY_MAX     = 8'h06;
  localparam logic [7:0] DAY_31       = 8'h31;
  localparam logic [7:0] DAY_30       = 8'h30;
  localparam logic [7:0] DAY_29       = 8'h29;
  localparam logic [7:0] DAY_28       = 8'h28;
  localparam logic [7:0] MON_FEB      = 8'h02;
  localparam logic [7:0] MON_APR      = 8'h04;
  localparam logic [7:0] MON_JUN      = 8'h06;
  localparam logic [7:0] MON_SEP      = 8'h09;
  localparam logic [7:0] MON_NOV      = 8'h11;
  localparam logic [7:0] HOUR_MASK12  = 8'h7f;

  // Slow clock periods in one second
  localparam int SUBSEC_PERIODS = 32768;

  typedef enum logic [1:0] {
    BCT_PER_SEC,
    BCT_PER_MIN,
    BCT_PER_HOUR,
    BCT_PER_DAY
  } bct_period_e;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] wday;
  } bct_time_s;

  localparam bct_time_s TIME_RESET = '{sec: 8'h00, min: 8'h00,
    hour: 8'h00, day: 8'h01, month: 8'h01, year: 8'h00, wday: 8'h00};

endpackage : bct_pkg

// ### hw/bct_timekeeper.sv
// BCD time and calendar counter with alarm, tick and compensation
`timescale 1ns/1ps
`default_nettype none

module bct_timekeeper #(
  parameter int SUBSEC = bct_pkg::SUBSEC_PERIODS
) (
  // Clock and resets
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       por,
  // Slow clock pin and power state
  input  wire logic       clk32_in,
  input  wire logic       sleep_state,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  // Events
  output logic            periodic_tick_event,
  output logic            alarm_match_event
);

  localparam int CW = 18;

  bct_pkg::bct_time_s tm;
  bct_pkg::bct_time_s nt;
  bct_pkg::bct_time_s alarm;
  logic [7:0]  ctrl;
  logic [4:0]  evt_ctrl;
  logic [15:0] comp;
  logic [7:0]  scratch [bct_pkg::SCRATCH_NUM];
  logic        running;
  logic [CW-1:0] subsec;
  logic [CW-1:0] limit;
  logic [CW-1:0] next_limit;
  logic        sync1;
  logic        sync2;
  logic        sync3;
  logic        tick32;
  logic        sec_end;
  logic        c_min;
  logic        c_hr;
  logic        c_day;
  logic        alarm_check;
  logic        mask_active;
  logic        period_hit;
  logic        wr_ctrl;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == bct_pkg::BCD_NINE) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                (y[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    if (m == bct_pkg::MON_FEB) begin
      last_day = is_leap(y) ? bct_pkg::DAY_29 : bct_pkg::DAY_28;
    end else if (m == bct_pkg::MON_APR || m == bct_pkg::MON_JUN ||
                 m == bct_pkg::MON_SEP || m == bct_pkg::MON_NOV) begin
      last_day = bct_pkg::DAY_30;
    end else begin
      last_day = bct_pkg::DAY_31;
    end
  endfunction

  // Slow clock pin synchroniser and edge detect
  // Only power-on reset clears it, so a general reset
  // neither loses nor invents a slow clock edge
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= clk32_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign tick32 = sync2 && !sync3;

  // Halt takes effect at slow clock edge
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      running <= 1'b0;
    end else if (tick32) begin
      running <= ctrl[bct_pkg::CTRL_RUN];
    end
  end

  assign sec_end = running && tick32 && (subsec == limit - 18'd1);

  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      subsec <= '0;
    end else if (sec_end) begin
      subsec <= '0;
    end else if (running && tick32) begin
      subsec <= subsec + 18'd1;
    end
  end

  // Compensated second at hour plus one
  always_comb begin
    next_limit = CW'(SUBSEC);
    if (ctrl[bct_pkg::CTRL_AUTO_COMP] && nt.min == bct_pkg::BCD_ZERO &&
        nt.sec == bct_pkg::BCD_ONE) begin
      next_limit = CW'(SUBSEC) - {{2{comp[15]}}, comp};
    end
  end

  // Latest value taken at the event
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      limit <= CW'(SUBSEC);
    end else if (sec_end) begin
      limit <= next_limit;
    end
  end

  // Next time and calendar values
  always_comb begin
    nt    = tm;
    c_min = 1'b0;
    c_hr  = 1'b0;
    c_day = 1'b0;
    if (sec_end) begin
      if (ctrl[bct_pkg::CTRL_ROUND]) begin
        nt.sec = bct_pkg::BCD_ZERO;
        c_min  = (tm.sec >= bct_pkg::SEC_HALF);
      end else if (tm.sec == bct_pkg::SEC_MAX) begin
        nt.sec = bct_pkg::BCD_ZERO;
        c_min  = 1'b1;
      end else begin
        nt.sec = bcd_inc(tm.sec);
      end
    end
    if (c_min) begin
      if (tm.min == bct_pkg::SEC_MAX) begin
        nt.min = bct_pkg::BCD_ZERO;
        c_hr   = 1'b1;
      end else begin
        nt.min = bcd_inc(tm.min);
      end
    end
    if (c_hr) begin
      if (ctrl[bct_pkg::CTRL_MODE_12H]) begin
        if ((tm.hour & bct_pkg::HOUR_MASK12) == bct_pkg::HOUR12_MAX) begin
          nt.hour = {tm.hour[bct_pkg::HOUR_PM_BIT], 7'h01};
        end else if ((tm.hour & bct_pkg::HOUR_MASK12) ==
                     bct_pkg::HOUR12_LAST) begin
          nt.hour = {!tm.hour[bct_pkg::HOUR_PM_BIT], 7'h12};
          c_day   = tm.hour[bct_pkg::HOUR_PM_BIT];
        end else begin
          nt.hour = bcd_inc(tm.hour);
        end
      end else if (tm.hour == bct_pkg::HOUR24_MAX) begin
        nt.hour = bct_pkg::BCD_ZERO;
        c_day   = 1'b1;
      end else begin
        nt.hour = bcd_inc(tm.hour);
      end
    end
    if (c_day) begin
      nt.wday = (tm.wday == bct_pkg::WDAY_MAX) ? bct_pkg::BCD_ZERO :
                bcd_inc(tm.wday);
      if (tm.day >= last_day(tm.month, tm.year)) begin
        nt.day = bct_pkg::BCD_ONE;
        if (tm.month == bct_pkg::MONTH_MAX) begin
          nt.month = bct_pkg::BCD_ONE;
          nt.year  = (tm.year == bct_pkg::YEAR_MAX) ? bct_pkg::BCD_ZERO :
                     bcd_inc(tm.year);
        end else begin
          nt.month = bcd_inc(tm.month);
        end
      end else begin
        nt.day = bcd_inc(tm.day);
      end
    end
  end

  // Writes taken while running, write wins
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      tm <= bct_pkg::TIME_RESET;
    end else begin
      tm <= nt;
      if (wr_en) begin
        unique case (addr)
          bct_pkg::REG_SECONDS:  tm.sec   <= wr_data;
          bct_pkg::REG_MINUTES:  tm.min   <= wr_data;
          bct_pkg::REG_HOURS:    tm.hour  <= wr_data;
          bct_pkg::REG_DAYS:     tm.day   <= wr_data;
          bct_pkg::REG_MONTHS:   tm.month <= wr_data;
          bct_pkg::REG_YEARS:    tm.year  <= wr_data;
          bct_pkg::REG_WEEKDAYS: tm.wday  <= wr_data;
          default: ;
        endcase
      end
    end
  end

  // Alarm, compensation and scratch storage
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      alarm <= bct_pkg::TIME_RESET;
      comp  <= '0;
      for (int i = 0; i < bct_pkg::SCRATCH_NUM; i++) begin
        scratch[i] <= '0;
      end
    end else if (wr_en) begin
      unique case (addr)
        bct_pkg::REG_AL_SEC:   alarm.sec   <= wr_data;
        bct_pkg::REG_AL_MIN:   alarm.min   <= wr_data;
        bct_pkg::REG_AL_HOUR:  alarm.hour  <= wr_data;
        bct_pkg::REG_AL_DAY:   alarm.day   <= wr_data;
        bct_pkg::REG_AL_MONTH: alarm.month <= wr_data;
        bct_pkg::REG_AL_YEAR:  alarm.year  <= wr_data;
        bct_pkg::REG_COMP_LSB: comp[7:0]   <= wr_data;
        bct_pkg::REG_COMP_MSB: comp[15:8]  <= wr_data;
        default: begin
          for (int i = 0; i < bct_pkg::SCRATCH_NUM; i++) begin
            if (addr == bct_pkg::REG_SCRATCH0 + 8'(i)) begin
              scratch[i] <= wr_data;
            end
          end
        end
      endcase
    end
  end

  assign wr_ctrl = wr_en && (addr == bct_pkg::REG_CTRL);

  // Control register
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      ctrl <= '0;
    end else if (wr_ctrl) begin
      ctrl <= wr_data;
    end else if (sec_end) begin
      ctrl[bct_pkg::CTRL_ROUND] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      evt_ctrl <= '0;
    end else if (wr_en && addr == bct_pkg::REG_EVT_CTRL) begin
      evt_ctrl <= wr_data[4:0];
    end
  end

  // Sleep mask set in sleep, cleared on wakeup
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      mask_active <= 1'b0;
    end else if (!sleep_state) begin
      mask_active <= 1'b0;
    end else if (evt_ctrl[bct_pkg::EVT_SLEEP_MASK]) begin
      mask_active <= 1'b1;
    end
  end

  always_comb begin
    unique case (bct_pkg::bct_period_e'(evt_ctrl[1:0]))
      bct_pkg::BCT_PER_SEC:  period_hit = sec_end;
      bct_pkg::BCT_PER_MIN:  period_hit = c_min;
      bct_pkg::BCT_PER_HOUR: period_hit = c_hr;
      bct_pkg::BCT_PER_DAY:  period_hit = c_day;
    endcase
  end

  // Event pulses
  always_ff @(posedge clk or posedge rst or posedge por) begin
    if (rst || por) begin
      periodic_tick_event <= 1'b0;
      alarm_check         <= 1'b0;
      alarm_match_event   <= 1'b0;
    end else begin
      periodic_tick_event <= period_hit &&
                             evt_ctrl[bct_pkg::EVT_TICK_EN] && !mask_active;
      alarm_check         <= sec_end;
      alarm_match_event   <= alarm_check &&
                             evt_ctrl[bct_pkg::EVT_ALARM_EN] &&
                             tm.sec == alarm.sec && tm.min == alarm.min &&
                             tm.hour == alarm.hour && tm.day == alarm.day &&
                             tm.month == alarm.month &&
                             tm.year == alarm.year;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge rst or posedge por) begin
    if (rst || por) begin
      rd_data <= '0;
    end else if (rd_en) begin
      unique case (addr)
        bct_pkg::REG_SECONDS:  rd_data <= tm.sec;
        bct_pkg::REG_MINUTES:  rd_data <= tm.min;
        bct_pkg::REG_HOURS:    rd_data <= tm.hour;
        bct_pkg::REG_DAYS:     rd_data <= tm.day;
        bct_pkg::REG_MONTHS:   rd_data <= tm.month;
        bct_pkg::REG_YEARS:    rd_data <= tm.year;
        bct_pkg::REG_WEEKDAYS: rd_data <= tm.wday;
        bct_pkg::REG_AL_SEC:   rd_data <= alarm.sec;
        bct_pkg::REG_AL_MIN:   rd_data <= alarm.min;
        bct_pkg::REG_AL_HOUR:  rd_data <= alarm.hour;
        bct_pkg::REG_AL_DAY:   rd_data <= alarm.day;
        bct_pkg::REG_AL_MONTH: rd_data <= alarm.month;
        bct_pkg::REG_AL_YEAR:  rd_data <= alarm.year;
        bct_pkg::REG_CTRL:     rd_data <= ctrl;
        bct_pkg::REG_STATUS: begin
          rd_data                        <= '0;
          rd_data[bct_pkg::STAT_RUNNING] <= running;
        end
        bct_pkg::REG_EVT_CTRL: rd_data <= {3'h0, evt_ctrl};
        bct_pkg::REG_COMP_LSB: rd_data <= comp[7:0];
        bct_pkg::REG_COMP_MSB: rd_data <= comp[15:8];
        default: begin
          rd_data <= '0;
          for (int i = 0; i < bct_pkg::SCRATCH_NUM; i++) begin
            if (addr == bct_pkg::REG_SCRATCH0 + 8'(i)) begin
              rd_data <= scratch[i];
            end
          end
        end
      endcase
    end
  end

endmodule // bct_timekeeper

`default_nettype wire

// ### verification/bct_timekeeper_properties.sv
// Port checker of the BCD calendar timekeeper
`timescale 1ns/1ps
`default_nettype none

module bct_timekeeper_properties #(
  parameter int SUBSEC = bct_pkg::SUBSEC_PERIODS
) (
  // Clock, resets, slow clock, power state
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       por,
  input wire logic       clk32_in,
  input wire logic       sleep_state,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  // Events
  input wire logic       periodic_tick_event,
  input wire logic       alarm_match_event
);
  logic [7:0] evt;
  logic       run_rq;
  logic [2:0] slow_q;
  logic [1:0] stop_edges;

  // Shadow of event control, kept over general reset
  always_ff @(posedge clk or posedge por) begin
    if (por)
      evt <= 8'h00;
    else if (wr_en && addr == bct_pkg::REG_EVT_CTRL)
      evt <= wr_data;
  end

  always_ff @(posedge clk or posedge por) begin
    if (por)
      run_rq <= 1'b0;
    else if (wr_en && addr == bct_pkg::REG_CTRL)
      run_rq <= wr_data[bct_pkg::CTRL_RUN];
  end

  always_ff @(posedge clk or posedge por) begin
    if (por)
      slow_q <= 3'h0;
    else
      slow_q <= {slow_q[1:0], clk32_in};
  end

  // Slow edges seen since the run request fell
  always_ff @(posedge clk or posedge por) begin
    if (por)
      stop_edges <= 2'd0;
    else if (run_rq)
      stop_edges <= 2'd0;
    else if (slow_q[1] && !slow_q[2] && stop_edges != 2'd3)
      stop_edges <= stop_edges + 2'd1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || por);

  sequence alarm_off;
    (!evt[bct_pkg::EVT_ALARM_EN]) [*3];
  endsequence

  sequence asleep;
    (sleep_state && evt[bct_pkg::EVT_SLEEP_MASK]) [*4];
  endsequence

  sequence scr_wr_rd;
    (wr_en && addr >= bct_pkg::REG_SCRATCH0 && addr < 8'h1a)
      ##2 (rd_en && addr == $past(addr, 2));
  endsequence

  AST_TICK_PULSE: assert property (periodic_tick_event |=>
    !periodic_tick_event) else $error("tick pulse too long");
  AST_ALARM_PULSE: assert property (alarm_match_event |=>
    !alarm_match_event) else $error("alarm pulse too long");
  AST_TICK_GATED: assert property (!evt[2] && !$past(evt[2])
    && !$past(evt[2], 2) |-> !periodic_tick_event)
    else $error("tick while disabled");
  AST_ALARM_GATED: assert property (alarm_off |->
    !alarm_match_event) else $error("alarm while disabled");
  AST_SLEEP_MASK: assert property (asleep |->
    !periodic_tick_event) else $error("tick while masked");
  AST_STOPPED: assert property (stop_edges == 2'd3 |->
    !periodic_tick_event) else $error("tick while stopped");
  AST_RD_HOLD: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved");
  AST_SCRATCH_RW: assert property (scr_wr_rd |=>
    rd_data == $past(wr_data, 3)) else $error("scratch lost");
  AST_UNMAPPED: assert property (rd_en && addr == 8'h07 |=>
    rd_data == 8'h00) else $error("unmapped read not zero");
  AST_POR_QUIET: assert property (disable iff (rst) $past(por) |->
    !periodic_tick_event && !alarm_match_event && rd_data == 8'h00)
    else $error("outputs active in power-on reset");
endmodule // bct_timekeeper_properties

bind bct_timekeeper bct_timekeeper_properties #(.SUBSEC(SUBSEC)) i_props (
  .clk(clk), .rst(rst), .por(por), .clk32_in(clk32_in),
  .sleep_state(sleep_state), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .periodic_tick_event(periodic_tick_event),
  .alarm_match_event(alarm_match_event)
);

`default_nettype wire

// ### verification/bct_timekeeper_tb_top.sv
// Self-checking bench of the BCD calendar timekeeper
`timescale 1ns/1ps
`default_nettype none

module bct_timekeeper_tb_top;
  localparam int SUB = 8;
  localparam int SPP = 8;
  logic       clk         = 1'b0;
  logic       rst         = 1'b1;
  logic       por         = 1'b1;
  logic       clk32_in    = 1'b0;
  logic       sleep_state = 1'b0;
  logic [7:0] addr        = 8'h00;
  logic [7:0] wr_data     = 8'h00;
  logic       wr_en       = 1'b0;
  logic       rd_en       = 1'b0;
  logic [7:0] rd_data;
  logic       periodic_tick_event;
  logic       alarm_match_event;
  logic [7:0] rv;
  int         err_count   = 0;
  int         checks      = 0;

  always #10 clk = ~clk;
  always #80 clk32_in = ~clk32_in;

  bct_timekeeper #(.SUBSEC(SUB)) i_dut (
    .clk(clk), .rst(rst), .por(por), .clk32_in(clk32_in),
    .sleep_state(sleep_state), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .periodic_tick_event(periodic_tick_event),
    .alarm_match_event(alarm_match_event)
  );

  task automatic close_out;
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask

  task automatic rc(string n, logic [7:0] a, logic [7:0] e);
    rd(a);
    chk(n, e, rv);
  endtask

  task automatic st(logic [7:0] b, logic [47:0] v);
    for (int i = 0; i < 6; i++)
      wr(b + 8'(i), v[8*i +: 8]);
  endtask

  task automatic ct(logic [47:0] e);
    for (int i = 0; i < 6; i++)
      rc("time field", 8'(i), e[8*i +: 8]);
  endtask

  task automatic ctl(logic [7:0] c);
    wr(bct_pkg::REG_CTRL, c);
  endtask

  task automatic halt(logic [7:0] c);
    ctl(c);
    for (int i = 0; i < 40; i++) begin
      rd(bct_pkg::REG_STATUS);
      if (rv[bct_pkg::STAT_RUNNING] === c[0])
        break;
    end
    chk("running", {7'h00, c[0]},
        {7'h00, rv[bct_pkg::STAT_RUNNING]});
  endtask

  task automatic wtk(bit alm);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if ((alm ? alarm_match_event : periodic_tick_event) === 1'b1)
        break;
    end
    if (i == 400)
      chk("event seen", 8'h01, 8'h00);
  endtask

  task automatic msr(logic [7:0] e);
    int n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (periodic_tick_event !== 1'b1 && n < 400);
    chk("second length", e, 8'(n));
  endtask

  task automatic t_scratch;
    ct(48'h00_01_01_00_00_00);
    for (int i = 0; i < bct_pkg::SCRATCH_NUM; i++) begin
      wr(bct_pkg::REG_SCRATCH0 + 8'(i), 8'h5a ^ 8'(i));
      rc("scratch", bct_pkg::REG_SCRATCH0 + 8'(i), 8'h5a ^ 8'(i));
    end
    wr(bct_pkg::REG_SECONDS, 8'h42);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < bct_pkg::SCRATCH_NUM; i++)
      rc("kept", bct_pkg::REG_SCRATCH0 + 8'(i), 8'h5a ^ 8'(i));
    rc("kept seconds", bct_pkg::REG_SECONDS, 8'h42);
    rc("unmapped", 8'h07, 8'h00);
  endtask

  task automatic t_cal;
    logic [47:0] c [7] = '{48'h03_02_28_03_03_01, 48'h04_02_28_04_02_29,
      48'h04_02_29_04_03_01, 48'h05_04_30_05_05_01, 48'h05_07_30_05_07_31,
      48'h05_12_31_06_01_01, 48'h99_12_31_00_01_01};
    wr(bct_pkg::REG_EVT_CTRL, 8'h04);
    foreach (c[i]) begin
      halt(8'h00);
      st(8'h00, {c[i][47:24], 24'h23_59_59});
      wr(bct_pkg::REG_WEEKDAYS, 8'h06);
      ctl(8'h01);
      wtk(1'b0);
      ct({c[i][23:0], 24'h00_00_00});
      rc("weekday", bct_pkg::REG_WEEKDAYS, 8'h00);
    end
  endtask

  task automatic t_12h;
    logic [15:0] c [3] = '{16'h11_92, 16'h91_12, 16'h92_81};
    halt(8'h00);
    ctl(8'h20);
    foreach (c[i]) begin
      st(8'h00, {24'h00_01_01, c[i][15:8], 16'h59_59});
      ctl(8'h21);
      wtk(1'b0);
      rc("hour", bct_pkg::REG_HOURS, c[i][7:0]);
      halt(8'h20);
    end
    ctl(8'h00);
  endtask

  task automatic t_round;
    logic [47:0] c [2] = '{48'h00_00_30_11_00_00, 48'h00_00_29_10_59_00};
    foreach (c[i]) begin
      halt(8'h00);
      st(8'h00, {24'h00_01_01, 16'h10_59, c[i][31:24]});
      ctl(8'h03);
      for (int k = 0; k < 60; k++) begin
        rd(bct_pkg::REG_CTRL);
        if (rv[bct_pkg::CTRL_ROUND] !== 1'b1)
          break;
      end
      chk("ctrl", 8'h01, rv);
      halt(8'h00);
      ct({24'h00_01_01, c[i][23:0]});
    end
  endtask

  task automatic t_period;
    logic [31:0] c [3] = '{32'h05_00_00_58, 32'h06_00_59_58,
      32'h07_23_59_58};
    foreach (c[i]) begin
      halt(8'h00);
      wr(bct_pkg::REG_EVT_CTRL, c[i][31:24]);
      st(8'h00, {24'h00_01_01, c[i][23:0]});
      ctl(8'h01);
      wtk(1'b0);
      rc("tick seconds", bct_pkg::REG_SECONDS, 8'h00);
    end
  endtask

  task automatic t_alarm;
    halt(8'h00);
    wr(bct_pkg::REG_EVT_CTRL, 8'h08);
    st(8'h00, 48'h00_01_01_10_00_00);
    st(bct_pkg::REG_AL_SEC, 48'h00_01_01_10_00_02);
    ctl(8'h01);
    wtk(1'b1);
    rc("alarm seconds", bct_pkg::REG_SECONDS, 8'h02);
  endtask

  task automatic t_sleep;
    int n = 0;
    halt(8'h00);
    wr(bct_pkg::REG_EVT_CTRL, 8'h14);
    sleep_state <= 1'b1;
    ctl(8'h01);
    repeat (200) begin
      @(posedge clk);
      #1;
      if (periodic_tick_event === 1'b1)
        n++;
    end
    chk("masked ticks", 8'h00, 8'(n));
    @(posedge clk);
    sleep_state <= 1'b0;
    wtk(1'b0);
  endtask

  task automatic t_run_write;
    wr(bct_pkg::REG_SECONDS, 8'h10);
    wtk(1'b0);
    rc("running write", bct_pkg::REG_SECONDS, 8'h11);
    halt(8'h00);
  endtask

  task automatic t_comp;
    wr(bct_pkg::REG_EVT_CTRL, 8'h04);
    wr(bct_pkg::REG_COMP_LSB, 8'h00);
    wr(bct_pkg::REG_COMP_MSB, 8'h00);
    st(8'h00, 48'h00_01_01_00_59_59);
    ctl(8'h05);
    wtk(1'b0);
    wr(bct_pkg::REG_COMP_LSB, 8'h02);
    wtk(1'b0);
    msr(8'((SUB - 2) * SPP));
    msr(8'(SUB * SPP));
  endtask

  initial begin
    repeat (20) @(posedge clk);
    por <= 1'b0;
    rst <= 1'b0;
    t_scratch();
    t_cal();
    t_12h();
    t_round();
    t_period();
    t_alarm();
    t_sleep();
    t_run_write();
    t_comp();
    close_out();
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule // bct_timekeeper_tb_top

`default_nettype wire
